// ### src/usi_regs.vh
// Register map, field positions, reset values and timing counts of the
// status interrupt logic.
// Assumes a 10 MHz core clock and a 32-bit AHB-Lite register bus.
`ifndef USI_REGS_VH
`define USI_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define USI_OFS_FLAGS        8'h00
`define USI_OFS_ENABLES      8'h04
`define USI_OFS_DEVADDR      8'h08
`define USI_OFS_CONTROL      8'h0c

// ****************************************
// Status flag and enable bit positions
// ****************************************
`define USI_BIT_BUS_RESET    0
`define USI_BIT_ERR_SUMMARY  1
`define USI_BIT_ACTIVITY     2
`define USI_BIT_TRN_DONE     3
`define USI_BIT_BUS_IDLE     4
`define USI_BIT_STALL_SENT   5
`define USI_BIT_FRAME_START  6
`define USI_BIT_UNUSED       7

// ****************************************
// Control register bit positions
// ****************************************
`define USI_CTL_SUSPEND      0
`define USI_CTL_USE_PLL      1
`define USI_CTL_OPERATIONAL  2

// ****************************************
// Reset values
// ****************************************
`define USI_RST_FLAGS        8'h00
`define USI_RST_ENABLES      8'h00
`define USI_RST_DEVADDR      7'h00
`define USI_RST_CONTROL      2'h0

// Bits software may write in the flag register (summary bit and bit 7 excluded).
`define USI_FLAG_WR_MASK     8'h7d

// ****************************************
// Timing
// ****************************************
`define USI_CLK_MHZ          10
`define USI_IDLE_TIME_US     3000
`define USI_IDLE_CYCLES      (`USI_IDLE_TIME_US * `USI_CLK_MHZ)
`define USI_WAKE_SYNC_CYCLES 4

`endif

// ### src/usi_sync3.v
// Three-stage synchroniser for one level from outside the clock domain.
// Assumes the output is used only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none

module usi_sync3 (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Level in and out
  input  wire async_in,
  output wire sync_out
);

  reg stage1_r;
  reg stage2_r;
  reg stage3_r;
  reg level_r;

  // ****************************************
  // Capture stages
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
      level_r  <= 1'b0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r) begin
        level_r <= stage3_r;
      end
    end
  end

  assign sync_out = level_r;

endmodule
`default_nettype wire

// ### src/usi_status_irq.v
// Top-level status interrupt logic of a full-speed USB device peripheral.
// Assumes one-cycle event pulses from the serial interface engine on core_clk,
// second-level error flags and enables supplied as levels, and one AHB-Lite master.
`timescale 1ns/100ps
`default_nettype none
`include "usi_regs.vh"

// Notes on behaviour
// - Enabled flags are ORed into one interrupt request.
// - A flag other than bit 1 stays set until software writes zero to it.
// - Software writing one to a writable flag sets it.
// - Bit 7 of flags and enables is absent and reads zero.
// - Bit 6 flags a received start-of-frame token.
// - Bit 5 flags a sent STALL handshake.
// - Bit 4 flags a bus idle for at least 3 ms.
// - Bit 3 flags a completed transaction; transfer status valid.
// - Clearing bit 3 advances the transfer status FIFO.
// - Bit 2 flags activity on the D+ or D- lines.
// - Bit 1 is set only by enabled second-level errors.
// - Bit 1 is read-only; software writes never change it.
// - Bus reset sets bit 0 and zeroes the device address.
// - Enables gate only the request; flags still set while disabled.
// - Activity flag ignores clears while suspended and shortly after wake.
// - With PLL clocking, the block waits for lock after suspend ends.
// - One activity event per resume; re-arms only after a new idle.
// - Error summary is OR of error flags gated by their enables.
module usi_status_irq #(
  parameter IDLE_CYCLES = `USI_IDLE_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Serial interface engine events
  input  wire        sie_frame_start,
  input  wire        sie_stall_sent,
  input  wire        sie_trn_done,
  input  wire        sie_bus_reset,
  input  wire        sie_line_idle,
  input  wire        sie_line_activity,
  // Second-level error flags and enables
  input  wire [7:0]  error_source_flags,
  input  wire [7:0]  error_source_enables,
  // PLL lock pin
  input  wire        pll_locked,
  // Outputs to the rest of the peripheral
  output wire        peripheral_irq_request,
  output wire        transfer_status_advance,
  output wire [6:0]  device_address,
  output wire        suspend_control_bit,
  output wire        module_operational
);

  // ****************************************
  // Local constants and state
  // ****************************************
  localparam integer IDLE_LAST_I = IDLE_CYCLES - 1;
  localparam integer WAKE_LAST_I = `USI_WAKE_SYNC_CYCLES - 1;
  localparam [14:0]  IDLE_LAST   = IDLE_LAST_I[14:0];
  localparam [2:0]   WAKE_LAST   = WAKE_LAST_I[2:0];
  localparam [7:0]   FLAGS_RST   = `USI_RST_FLAGS;
  localparam [7:0]   ENABLES_RST = `USI_RST_ENABLES;

  localparam [1:0] PWR_RUN     = 2'h0;
  localparam [1:0] PWR_SUSPEND = 2'h1;
  localparam [1:0] PWR_LOCK    = 2'h2;
  localparam [1:0] PWR_SYNC    = 2'h3;

  reg  [6:0]  flags_r;
  reg  [6:0]  flags_nxt;
  reg  [6:0]  enables_r;
  reg  [6:0]  devaddr_r;
  reg  [1:0]  control_r;
  reg  [1:0]  pwr_state_r;
  reg  [1:0]  pwr_state_nxt;
  reg  [2:0]  wake_cnt_r;
  reg  [14:0] idle_cnt_r;
  reg         idle_fired_r;
  reg         act_armed_r;
  reg         advance_r;
  reg         wr_pend_r;
  reg         rd_wait_r;
  reg  [7:0]  addr_r;
  reg  [31:0] hrdata_r;
  reg  [7:0]  rd_val;

  wire        pll_locked_s;
  wire        addr_phase;
  wire        wr_now;
  wire        err_summary;
  wire [7:0]  flags_view;
  wire [7:0]  enables_view;
  wire        idle_event;
  wire        act_event;
  wire        act_clear_ok;
  wire        wr_flags;
  wire [7:0]  wmask;
  wire        wr_enables;
  wire        wr_devaddr;
  wire        wr_control;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  usi_sync3 u_pll_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pll_locked),
    .sync_out (pll_locked_s)
  );

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_now     = wr_pend_r;
  assign hreadyout  = ~rd_wait_r;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= 32'h00000000;
    end else begin
      if (hready) begin
        wr_pend_r <= addr_phase & hwrite;
        rd_wait_r <= addr_phase & ~hwrite;
        if (addr_phase) begin
          addr_r <= haddr;
        end
      end else begin
        wr_pend_r <= 1'b0;
        rd_wait_r <= 1'b0;
      end
      if (rd_wait_r) begin
        hrdata_r <= {24'h000000, rd_val};
      end
    end
  end

  // Reads take one wait state so the data comes from a flip-flop.
  always @* begin
    case (addr_r)
      `USI_OFS_FLAGS:   rd_val = flags_view;
      `USI_OFS_ENABLES: rd_val = enables_view;
      `USI_OFS_DEVADDR: rd_val = {1'b0, devaddr_r};
      `USI_OFS_CONTROL: rd_val = {5'h00, module_operational, control_r};
      default:          rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // Second-level error summary
  // ****************************************
  assign err_summary = |(error_source_flags & error_source_enables);

  // Bit 7 is absent; bit 1 is the live error summary.
  assign flags_view   = {1'b0, flags_r[6:2], err_summary, flags_r[0]};
  assign enables_view = {1'b0, enables_r};

  // ****************************************
  // Interrupt request
  // ****************************************
  assign peripheral_irq_request = |(flags_view & enables_view);

  // ****************************************
  // Suspend and wake-up sequencing
  // ****************************************
  always @* begin
    pwr_state_nxt = pwr_state_r;
    case (pwr_state_r)
      PWR_RUN: begin
        if (control_r[`USI_CTL_SUSPEND]) begin
          pwr_state_nxt = PWR_SUSPEND;
        end
      end
      PWR_SUSPEND: begin
        if (!control_r[`USI_CTL_SUSPEND]) begin
          pwr_state_nxt = PWR_LOCK;
        end
      end
      PWR_LOCK: begin
        if (control_r[`USI_CTL_SUSPEND]) begin
          pwr_state_nxt = PWR_SUSPEND;
        end else if (!control_r[`USI_CTL_USE_PLL] || pll_locked_s) begin
          pwr_state_nxt = PWR_SYNC;
        end
      end
      PWR_SYNC: begin
        if (control_r[`USI_CTL_SUSPEND]) begin
          pwr_state_nxt = PWR_SUSPEND;
        end else if (wake_cnt_r == WAKE_LAST) begin
          pwr_state_nxt = PWR_RUN;
        end
      end
      default: pwr_state_nxt = PWR_RUN;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_state_r <= PWR_RUN;
      wake_cnt_r  <= 3'h0;
    end else begin
      pwr_state_r <= pwr_state_nxt;
      if (pwr_state_r == PWR_SYNC) begin
        wake_cnt_r <= wake_cnt_r + 3'h1;
      end else begin
        wake_cnt_r <= 3'h0;
      end
    end
  end

  assign module_operational = (pwr_state_r == PWR_RUN);
  assign act_clear_ok       = module_operational;

  // ****************************************
  // Idle detection and activity arming
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_cnt_r   <= 15'h0000;
      idle_fired_r <= 1'b0;
      act_armed_r  <= 1'b0;
    end else begin
      if (!sie_line_idle) begin
        idle_cnt_r   <= 15'h0000;
        idle_fired_r <= 1'b0;
      end else if (idle_cnt_r != IDLE_LAST) begin
        idle_cnt_r <= idle_cnt_r + 15'h0001;
      end else begin
        idle_fired_r <= 1'b1;
      end
      if (idle_event) begin
        act_armed_r <= 1'b1;
      end else if (act_event) begin
        act_armed_r <= 1'b0;
      end
    end
  end

  // One idle event per unbroken idle stretch of the full duration.
  assign idle_event = sie_line_idle & (idle_cnt_r == IDLE_LAST) & ~idle_fired_r;
  assign act_event  = sie_line_activity & act_armed_r;

  // ****************************************
  // Status flags
  // ****************************************
  assign wr_flags = wr_now & (addr_r == `USI_OFS_FLAGS);
  assign wmask    = `USI_FLAG_WR_MASK;

  always @* begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      // Writable bits take the written value: zero clears, one sets; bit 2 takes a zero only while operational.
      flags_nxt[0]   = hwdata[0];
      flags_nxt[6:3] = hwdata[6:3];
      if (act_clear_ok || hwdata[`USI_BIT_ACTIVITY]) begin
        flags_nxt[`USI_BIT_ACTIVITY] = hwdata[`USI_BIT_ACTIVITY];
      end
    end
    flags_nxt[1] = 1'b0;
    // Hardware events win over a clear in the same cycle.
    if (sie_frame_start) begin
      flags_nxt[`USI_BIT_FRAME_START] = 1'b1;
    end
    if (sie_stall_sent) begin
      flags_nxt[`USI_BIT_STALL_SENT] = 1'b1;
    end
    if (idle_event) begin
      flags_nxt[`USI_BIT_BUS_IDLE] = 1'b1;
    end
    if (sie_trn_done) begin
      flags_nxt[`USI_BIT_TRN_DONE] = 1'b1;
    end
    if (act_event) begin
      flags_nxt[`USI_BIT_ACTIVITY] = 1'b1;
    end
    if (sie_bus_reset) begin
      flags_nxt[`USI_BIT_BUS_RESET] = 1'b1;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_r   <= FLAGS_RST[6:0];
      advance_r <= 1'b0;
    end else begin
      flags_r   <= flags_nxt & wmask[6:0];
      // A transaction flag going from set to clear by software steps the FIFO.
      advance_r <= wr_flags & flags_r[`USI_BIT_TRN_DONE] & ~hwdata[`USI_BIT_TRN_DONE]
                   & ~sie_trn_done;
    end
  end

  assign transfer_status_advance = advance_r;

  // ****************************************
  // Enables, device address and control
  // ****************************************
  assign wr_enables = wr_now & (addr_r == `USI_OFS_ENABLES);
  assign wr_devaddr = wr_now & (addr_r == `USI_OFS_DEVADDR);
  assign wr_control = wr_now & (addr_r == `USI_OFS_CONTROL);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enables_r <= ENABLES_RST[6:0];
      devaddr_r <= `USI_RST_DEVADDR;
      control_r <= `USI_RST_CONTROL;
    end else begin
      if (wr_enables) begin
        enables_r <= hwdata[6:0];
      end
      if (sie_bus_reset) begin
        devaddr_r <= `USI_RST_DEVADDR;
      end else if (wr_devaddr) begin
        devaddr_r <= hwdata[6:0];
      end
      if (wr_control) begin
        control_r <= hwdata[1:0];
      end
    end
  end

  assign device_address      = devaddr_r;
  assign suspend_control_bit = control_r[`USI_CTL_SUSPEND];

endmodule
`default_nettype wire

// ### test/usi_properties.sv
// Checker for the status interrupt logic, bound to its top module.
// Assumes one AHB-Lite master with hready fed from hreadyout.
`timescale 1ns/100ps
`default_nettype none
`include "usi_regs.vh"
module usi_checker #(
  parameter IDLE_CYCLES = 20
) (
  // Clock, reset and bus
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // Events, levels and outputs
  input wire logic        sie_frame_start,
  input wire logic        sie_stall_sent,
  input wire logic        sie_trn_done,
  input wire logic        sie_bus_reset,
  input wire logic [7:0]  error_source_flags,
  input wire logic [7:0]  error_source_enables,
  input wire logic        peripheral_irq_request,
  input wire logic        transfer_status_advance,
  input wire logic [6:0]  device_address
);
  // ****************************************
  // Write tracking
  // ****************************************
  logic       wq_r;
  logic [7:0] aq_r;
  logic [7:0] en_r;
  wire        fwr = wq_r && hready && aq_r == `USI_OFS_FLAGS;
  wire        clr3 = fwr && !hwdata[3];
  wire        err = |(error_source_flags & error_source_enables);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wq_r <= 1'b0;
      aq_r <= 8'h00;
      en_r <= 8'h00;
    end else begin
      if (hready) begin
        wq_r <= hsel && htrans[1] && hwrite;
        aq_r <= haddr;
      end
      if (wq_r && hready && aq_r == `USI_OFS_ENABLES) en_r <= hwdata[7:0] & 8'h7f;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_evt(ev, b);
    ev && en_r[b] && !wq_r;
  endsequence
  property p_sof;   s_evt(sie_frame_start, 6) |=> peripheral_irq_request; endproperty
  property p_stall; s_evt(sie_stall_sent, 5) |=> peripheral_irq_request; endproperty
  property p_trn;   s_evt(sie_trn_done, 3) |=> peripheral_irq_request; endproperty
  property p_urst;  s_evt(sie_bus_reset, 0) |=> peripheral_irq_request; endproperty
  property p_addr;  sie_bus_reset |=> device_address == 7'h00; endproperty
  property p_hold;  peripheral_irq_request && !wq_r && !err |=> peripheral_irq_request; endproperty
  property p_err;   err && en_r[1] |-> peripheral_irq_request; endproperty
  property p_mask;  en_r == 8'h00 |-> !peripheral_irq_request; endproperty
  property p_adv;   transfer_status_advance |-> $past(clr3) || $past(clr3, 2); endproperty
  a_sof:   assert property (p_sof) else $error("frame start did not raise request");
  a_stall: assert property (p_stall) else $error("stall did not raise request");
  a_trn:   assert property (p_trn) else $error("transaction did not raise request");
  a_urst:  assert property (p_urst) else $error("bus reset did not raise request");
  a_addr:  assert property (p_addr) else $error("address not zeroed");
  a_hold:  assert property (p_hold) else $error("flag dropped without write");
  a_err:   assert property (p_err) else $error("error summary not requested");
  a_mask:  assert property (p_mask) else $error("request while all masked");
  a_adv:   assert property (p_adv) else $error("advance without clear");
endmodule
bind usi_status_irq usi_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_usi_checker (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .sie_frame_start(sie_frame_start),
  .sie_stall_sent(sie_stall_sent), .sie_trn_done(sie_trn_done),
  .sie_bus_reset(sie_bus_reset), .error_source_flags(error_source_flags),
  .error_source_enables(error_source_enables),
  .peripheral_irq_request(peripheral_irq_request),
  .transfer_status_advance(transfer_status_advance), .device_address(device_address));
`default_nettype wire

// ### test/usi_sie_model.sv
// Far-side model: engine event pulses, line states, error levels and lock.
// Assumes its tasks are called from one bench process.
`timescale 1ns/100ps
`default_nettype none
module usi_sie_model (
  // Clock
  input wire logic  core_clk,
  // Engine events and line states
  output logic      sie_frame_start,
  output logic      sie_stall_sent,
  output logic      sie_trn_done,
  output logic      sie_bus_reset,
  output logic      sie_line_idle,
  output logic      sie_line_activity,
  // Error levels and lock
  output logic [7:0] error_source_flags,
  output logic [7:0] error_source_enables,
  output logic      pll_locked
);
  initial begin
    {sie_frame_start, sie_stall_sent, sie_trn_done, sie_bus_reset} = 4'h0;
    {sie_line_idle, sie_line_activity, pll_locked} = 3'h0;
    {error_source_flags, error_source_enables} = 16'h0000;
  end
  // Bit 0 frame start, 1 stall, 2 transaction, 3 bus reset; one cycle each.
  task automatic fire(input logic [3:0] m);
    @(posedge core_clk);
    {sie_bus_reset, sie_trn_done, sie_stall_sent, sie_frame_start} <= m;
    @(posedge core_clk);
    {sie_bus_reset, sie_trn_done, sie_stall_sent, sie_frame_start} <= 4'h0;
    @(negedge core_clk);
  endtask
  task automatic lines(input logic idle, act, lock, input logic [7:0] ef, ee);
    @(posedge core_clk);
    sie_line_idle <= idle;
    sie_line_activity <= act;
    pll_locked <= lock;
    error_source_flags <= ef;
    error_source_enables <= ee;
  endtask
endmodule
`default_nettype wire

// ### test/test_usb_status_interrupt_logic.sv
// Bench for the status interrupt logic: bus tasks and register sequences.
// Assumes the checker is bound to the design and the engine model drives events.
`timescale 1ns/100ps
`default_nettype none
`include "usi_regs.vh"
module test_usb_status_interrupt_logic;
  localparam int         IDLE = 20;
  localparam logic [7:0] FL = `USI_OFS_FLAGS;
  localparam logic [7:0] EN = `USI_OFS_ENABLES;
  localparam logic [7:0] DA = `USI_OFS_DEVADDR;
  localparam logic [7:0] CT = `USI_OFS_CONTROL;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, adv, susp, op;
  wire         s_sof, s_stl, s_trn, s_rst, s_idle, s_act, lock;
  wire  [7:0]  ef, ee;
  wire  [6:0]  dev_addr;
  logic [31:0] q_r;
  logic [7:0]  ev [4] = '{8'h40, 8'h20, 8'h08, 8'h01};
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          adv_n = 0;
  int          n;
  always #50 core_clk = ~core_clk;
  usi_status_irq #(.IDLE_CYCLES(IDLE)) u_usi_status_irq (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sie_frame_start(s_sof), .sie_stall_sent(s_stl),
    .sie_trn_done(s_trn), .sie_bus_reset(s_rst), .sie_line_idle(s_idle),
    .sie_line_activity(s_act), .error_source_flags(ef), .error_source_enables(ee),
    .pll_locked(lock), .peripheral_irq_request(irq), .transfer_status_advance(adv),
    .device_address(dev_addr), .suspend_control_bit(susp), .module_operational(op));
  usi_sie_model u_usi_sie_model (
    .core_clk(core_clk), .sie_frame_start(s_sof), .sie_stall_sent(s_stl),
    .sie_trn_done(s_trn), .sie_bus_reset(s_rst), .sie_line_idle(s_idle),
    .sie_line_activity(s_act), .error_source_flags(ef), .error_source_enables(ee),
    .pll_locked(lock));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Single word transfer; ready is sampled at each rising edge.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q_r = hrdata;
    @(negedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("register %h", a), {24'h0, e}, q_r);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (adv === 1'b1) adv_n++;
    if (cyc == 4000) begin
      err_count++;
      test_done();
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rdc(FL, 8'h00);
    rdc(EN, 8'h00);
    xfer(8'h20, 1'b1, 32'hff);
    rdc(8'h20, 8'h00);
    xfer(EN, 1'b1, 32'hff);
    rdc(EN, 8'h7f);
    xfer(FL, 1'b1, 32'hff);
    rdc(FL, 8'h7d);
    chk("request", 1, irq);
    xfer(FL, 1'b1, 32'h0);
    rdc(FL, 8'h00);
    xfer(EN, 1'b1, 32'h0);
    xfer(DA, 1'b1, 32'h55);
    rdc(DA, 8'h55);
    for (int k = 0; k < 4; k++) begin
      u_usi_sie_model.fire(4'h1 << k);
      rdc(FL, ev[k]);
      chk("request", 0, irq);
      xfer(FL, 1'b1, {24'h0, ev[k]});
      xfer(EN, 1'b1, {24'h0, ev[k]});
      rdc(FL, ev[k]);
      chk("request", 1, irq);
      xfer(FL, 1'b1, 32'h0);
      chk("request", 0, irq);
      u_usi_sie_model.fire(4'h1 << k);
      chk("request", 1, irq);
      xfer(FL, 1'b1, 32'h0);
      xfer(EN, 1'b1, 32'h0);
    end
    chk("device address", 0, dev_addr);
    chk("advance pulses", 3, adv_n);
    u_usi_sie_model.lines(0, 0, 0, 8'h01, 8'h00);
    rdc(FL, 8'h00);
    u_usi_sie_model.lines(0, 0, 0, 8'h01, 8'h01);
    rdc(FL, 8'h02);
    xfer(FL, 1'b1, 32'h0);
    rdc(FL, 8'h02);
    xfer(EN, 1'b1, 32'h02);
    chk("request", 1, irq);
    xfer(EN, 1'b1, 32'h0);
    u_usi_sie_model.lines(1, 0, 0, 8'h00, 8'h00);
    repeat (IDLE / 2) @(posedge core_clk);
    u_usi_sie_model.lines(0, 0, 0, 8'h00, 8'h00);
    rdc(FL, 8'h00);
    u_usi_sie_model.lines(1, 0, 0, 8'h00, 8'h00);
    repeat (IDLE + 4) @(posedge core_clk);
    rdc(FL, 8'h10);
    xfer(EN, 1'b1, 32'h04);
    chk("request", 0, irq);
    u_usi_sie_model.lines(0, 1, 0, 8'h00, 8'h00);
    u_usi_sie_model.lines(0, 0, 0, 8'h00, 8'h00);
    rdc(FL, 8'h14);
    chk("request", 1, irq);
    xfer(FL, 1'b1, 32'h0);
    u_usi_sie_model.lines(0, 1, 0, 8'h00, 8'h00);
    u_usi_sie_model.lines(0, 0, 0, 8'h00, 8'h00);
    rdc(FL, 8'h00);
    chk("request", 0, irq);
    xfer(EN, 1'b1, 32'h0);
    xfer(CT, 1'b1, 32'h03);
    chk("suspend bit", 1, susp);
    @(negedge core_clk);
    chk("operational", 0, op);
    xfer(FL, 1'b1, 32'h04);
    xfer(FL, 1'b1, 32'h0);
    rdc(FL, 8'h04);
    rdc(CT, 8'h03);
    xfer(CT, 1'b1, 32'h02);
    chk("suspend bit", 0, susp);
    repeat (20) @(posedge core_clk);
    chk("operational", 0, op);
    u_usi_sie_model.lines(0, 0, 1, 8'h00, 8'h00);
    repeat (12) @(posedge core_clk);
    chk("operational", 1, op);
    xfer(CT, 1'b1, 32'h01);
    xfer(CT, 1'b1, 32'h00);
    xfer(FL, 1'b1, 32'h0);
    rdc(FL, 8'h04);
    n = 0;
    do begin
      xfer(FL, 1'b1, 32'h0);
      xfer(FL, 1'b0, 32'h0);
      n++;
    end while (q_r[2] !== 1'b0 && n < 10);
    chk("flags after wake", 0, q_r);
    chk("response", 0, hresp);
    test_done();
  end
endmodule
`default_nettype wire
